// ==== logic/pcsreg_defs.vh ====
`ifndef PCSREG_DEFS_VH
`define PCSREG_DEFS_VH

`define PCSREG_ADDR_CONTROL 5'h00
`define PCSREG_ADDR_STATUS 5'h01

`define PCSREG_CTL_RESET 15
`define PCSREG_CTL_LOOPBACK 14
`define PCSREG_CTL_SPEED_LSB 13
`define PCSREG_CTL_AN_ENABLE 12
`define PCSREG_CTL_POWER_DOWN 11
`define PCSREG_CTL_ISOLATE 10
`define PCSREG_CTL_AN_RESTART 9
`define PCSREG_CTL_DUPLEX 8
`define PCSREG_CTL_COL_TEST 7
`define PCSREG_CTL_SPEED_MSB 6
`define PCSREG_CTL_UNIDIR 5

`define PCSREG_CTL_AN_ENABLE_RST 1'b1
`define PCSREG_CTL_ISOLATE_RST 1'b1

`define PCSREG_STS_CONST 16'h01c8
`define PCSREG_STS_AN_DONE 5
`define PCSREG_STS_REMOTE_FAULT 4
`define PCSREG_STS_LINK 2

`define PCSREG_OP_WRITE 2'h1
`define PCSREG_OP_READ 2'h2

`define PCSREG_LINK_TIMER_NS 10000000
`define PCSREG_CLK_PERIOD_NS 40
`define PCSREG_LINK_TIMER_CYC 250000

`endif

// ==== logic/pcsreg_mdio_slave.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pcsreg_defs.vh"

// serial frame engine sampled on clk; mdc edges found from a synced copy
module pcsreg_mdio_slave
(
    input wire clk,
    input wire rst_n,
    input wire clkEn,
    input wire [4:0] phyAddr,
    input wire mdc,
    input wire mdioIn,
    output reg mdioOut,
    output reg mdioOe,
    output reg wrStb,
    output reg rdStb,
    output reg [4:0] regAddr,
    output reg [15:0] wrData,
    input wire [15:0] rdData
);

    localparam ST_IDLE = 2'h0;
    localparam ST_HDR = 2'h1;
    localparam ST_WDATA = 2'h2;
    localparam ST_RDATA = 2'h3;

    reg [1:0] mdcSync_q;
    reg [1:0] dinSync_q;
    reg mdcPrev_q;
    reg [1:0] state_q;
    reg [5:0] cnt_q;
    reg [5:0] ones_q;
    reg [13:0] hdr_q;
    reg [15:0] shift_q;
    reg isRead_q;
    wire mdcRise;
    wire mdcFall;
    wire din;
    wire [13:0] hdrNext;
    wire hit;

    assign mdcRise = mdcSync_q[1] & ~mdcPrev_q;
    assign mdcFall = ~mdcSync_q[1] & mdcPrev_q;
    assign din = dinSync_q[1];
    assign hdrNext = {hdr_q[12:0], din};
    // physical address 0 is answered too, as broadcast
    assign hit = (hdrNext[9:5] == phyAddr) || (hdrNext[9:5] == 5'h00);

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            mdcSync_q <= 2'h0;
            dinSync_q <= 2'h3;
            mdcPrev_q <= 1'b0;
            state_q <= ST_IDLE;
            cnt_q <= 6'h00;
            ones_q <= 6'h00;
            hdr_q <= 14'h0000;
            shift_q <= 16'h0000;
            isRead_q <= 1'b0;
            mdioOut <= 1'b1;
            mdioOe <= 1'b0;
            wrStb <= 1'b0;
            rdStb <= 1'b0;
            regAddr <= 5'h00;
            wrData <= 16'h0000;
        end
        else if (clkEn)
        begin
            mdcSync_q <= {mdcSync_q[0], mdc};
            dinSync_q <= {dinSync_q[0], mdioIn};
            mdcPrev_q <= mdcSync_q[1];
            wrStb <= 1'b0;
            rdStb <= 1'b0;
            if (mdcRise)
            begin
                case (state_q)
                    ST_IDLE:
                    begin
                        // preamble suppression: one idle bit then start 01
                        if (din)
                            ones_q <= (ones_q == 6'h3f) ? ones_q : ones_q + 6'h01;
                        else if (ones_q != 6'h00)
                        begin
                            state_q <= ST_HDR;
                            cnt_q <= 6'h00;
                            hdr_q <= 14'h0000;
                        end
                        if (!din)
                            ones_q <= 6'h00;
                    end
                    ST_HDR:
                    begin
                        hdr_q <= hdrNext;
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == 6'h00 && !din)
                            state_q <= ST_IDLE;
                        if (cnt_q == 6'h0c)
                        begin
                            // bits: start1 op2 phy5 reg5, last is here
                            regAddr <= hdrNext[4:0];
                            if (hit && hdrNext[11:10] == `PCSREG_OP_READ)
                            begin
                                isRead_q <= 1'b1;
                                rdStb <= 1'b1;
                                state_q <= ST_RDATA;
                            end
                            else if (hit && hdrNext[11:10] == `PCSREG_OP_WRITE)
                            begin
                                isRead_q <= 1'b0;
                                state_q <= ST_WDATA;
                            end
                            else
                                state_q <= ST_IDLE;
                            cnt_q <= 6'h00;
                        end
                    end
                    ST_WDATA:
                    begin
                        // two turnaround bits then 16 data bits
                        cnt_q <= cnt_q + 6'h01;
                        shift_q <= {shift_q[14:0], din};
                        if (cnt_q == 6'h11)
                        begin
                            wrData <= {shift_q[14:0], din};
                            wrStb <= 1'b1;
                            state_q <= ST_IDLE;
                            ones_q <= 6'h00;
                        end
                    end
                    default:
                        cnt_q <= cnt_q;
                endcase
            end
            if (rdStb)
                shift_q <= rdData;
            // read data changes on falling mdc so the master samples it stable
            if (mdcFall && state_q == ST_RDATA && isRead_q)
            begin
                cnt_q <= cnt_q + 6'h01;
                // first fall closes the address bit; line stays released
                // through the first turnaround bit to avoid a fight
                if (cnt_q == 6'h00)
                    mdioOe <= 1'b0;
                else if (cnt_q == 6'h01)
                begin
                    mdioOe <= 1'b1;
                    mdioOut <= 1'b0;
                end
                else if (cnt_q <= 6'h11)
                begin
                    mdioOut <= shift_q[15];
                    shift_q <= {shift_q[14:0], 1'b0};
                end
                else
                begin
                    mdioOe <= 1'b0;
                    mdioOut <= 1'b1;
                    state_q <= ST_IDLE;
                    ones_q <= 6'h00;
                    isRead_q <= 1'b0;
                end
            end
        end
    end

endmodule // pcsreg_mdio_slave
`default_nettype wire

// ==== logic/pcsreg_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pcsreg_defs.vh"

module pcsreg_top
#(
    parameter [1:0] TBI_VARIANT = 2'h0,
    parameter LINK_TIMER_CYC = `PCSREG_LINK_TIMER_CYC
)
(
    input wire clk,
    input wire rst_n,
    input wire clkEn,
    input wire clockLocked,
    input wire [4:0] phyAddr,
    input wire mdc,
    input wire mdioIn,
    output wire mdioOut,
    output wire mdioOe,
    input wire cfgValid,
    input wire [15:0] cfgVector,
    input wire syncStatus,
    input wire anComplete,
    input wire xcvrResetDone,
    input wire remoteFault,
    output reg coreReset,
    output reg loopbackInternal,
    output reg loopbackRequest,
    output reg powerDown,
    output reg isolate,
    output reg anEnable,
    output reg anRestart,
    output reg unidirTx
);

    wire wrStb;
    wire rdStb;
    wire [4:0] regAddr;
    wire [15:0] wrData;
    wire [15:0] readValue;
    reg [1:0] syncS_q;
    reg [1:0] anDoneS_q;
    reg [1:0] xcvrS_q;
    reg [1:0] rfS_q;
    reg [1:0] lockS_q;
    reg loopback_q;
    reg anEnable_q;
    reg powerDown_q;
    reg isolate_q;
    reg unidir_q;
    reg remoteFault_q;
    reg linkLatch_q;
    reg softReset_q;
    reg [17:0] lossCnt_q;
    reg syncHeld_q;
    wire linkNow;
    wire statusRead;
    wire anyReset;

    function [15:0] ctlWord;
        input lb;
        input ane;
        input pd;
        input iso;
        input uni;
        begin
            ctlWord = 16'h0000;
            ctlWord[`PCSREG_CTL_LOOPBACK] = lb;
            ctlWord[`PCSREG_CTL_AN_ENABLE] = ane;
            ctlWord[`PCSREG_CTL_POWER_DOWN] = pd;
            ctlWord[`PCSREG_CTL_ISOLATE] = iso;
            ctlWord[`PCSREG_CTL_DUPLEX] = 1'b1;
            ctlWord[`PCSREG_CTL_SPEED_MSB] = 1'b1;
            ctlWord[`PCSREG_CTL_UNIDIR] = uni;
        end
    endfunction

    pcsreg_mdio_slave u_mdio
    (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .phyAddr(phyAddr),
        .mdc(mdc),
        .mdioIn(mdioIn),
        .mdioOut(mdioOut),
        .mdioOe(mdioOe),
        .wrStb(wrStb),
        .rdStb(rdStb),
        .regAddr(regAddr),
        .wrData(wrData),
        .rdData(readValue)
    );

    // lock loss and soft reset act like the hardware reset here; the synchronizers and u_mdio are reset by rst_n only
    assign anyReset = !rst_n || !lockS_q[1] || softReset_q;
    assign statusRead = rdStb && regAddr == `PCSREG_ADDR_STATUS;
    // sync loss only counts once it has persisted a full link timer
    assign linkNow = syncHeld_q && xcvrS_q[1] &&
        (!anEnable_q || anDoneS_q[1]);

    // constant bits come from fixed terms, never from stored state
    assign readValue =
        (regAddr == `PCSREG_ADDR_CONTROL) ?
            ctlWord(loopback_q, anEnable_q, powerDown_q, isolate_q,
                    unidir_q) :
        (regAddr == `PCSREG_ADDR_STATUS) ?
            (`PCSREG_STS_CONST
             | ({15'h0000, anDoneS_q[1]} << `PCSREG_STS_AN_DONE)
             | ({15'h0000, remoteFault_q} << `PCSREG_STS_REMOTE_FAULT)
             | ({15'h0000, linkLatch_q} << `PCSREG_STS_LINK)) :
        16'h0000;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            syncS_q <= 2'h0;
            anDoneS_q <= 2'h0;
            xcvrS_q <= 2'h0;
            rfS_q <= 2'h0;
            lockS_q <= 2'h3;
        end
        else if (clkEn)
        begin
            syncS_q <= {syncS_q[0], syncStatus};
            anDoneS_q <= {anDoneS_q[0], anComplete};
            xcvrS_q <= {xcvrS_q[0], xcvrResetDone};
            rfS_q <= {rfS_q[0], remoteFault};
            lockS_q <= {lockS_q[0], clockLocked};
        end
    end

    always @(posedge clk)
    begin
        if (anyReset)
        begin
            loopback_q <= 1'b0;
            anEnable_q <= `PCSREG_CTL_AN_ENABLE_RST;
            powerDown_q <= 1'b0;
            isolate_q <= `PCSREG_CTL_ISOLATE_RST;
            unidir_q <= 1'b0;
            remoteFault_q <= 1'b0;
            linkLatch_q <= 1'b0;
            softReset_q <= 1'b0;
            lossCnt_q <= 18'h00000;
            syncHeld_q <= 1'b0;
            coreReset <= 1'b1;
            loopbackInternal <= 1'b0;
            loopbackRequest <= 1'b0;
            powerDown <= 1'b0;
            isolate <= 1'b1;
            anEnable <= 1'b1;
            anRestart <= 1'b0;
            unidirTx <= 1'b0;
        end
        else if (clkEn)
        begin
            anRestart <= 1'b0;
            coreReset <= 1'b0;
            if (wrStb && regAddr == `PCSREG_ADDR_CONTROL)
            begin
                // reset bit self-clears via the soft reset pulse
                softReset_q <= wrData[`PCSREG_CTL_RESET];
                loopback_q <= wrData[`PCSREG_CTL_LOOPBACK];
                anEnable_q <= wrData[`PCSREG_CTL_AN_ENABLE];
                powerDown_q <= powerDown_q |
                    wrData[`PCSREG_CTL_POWER_DOWN];
                isolate_q <= wrData[`PCSREG_CTL_ISOLATE];
                unidir_q <= wrData[`PCSREG_CTL_UNIDIR];
                anRestart <= wrData[`PCSREG_CTL_AN_RESTART];
            end
            else if (cfgValid)
            begin
                softReset_q <= cfgVector[`PCSREG_CTL_RESET];
                loopback_q <= cfgVector[`PCSREG_CTL_LOOPBACK];
                anEnable_q <= cfgVector[`PCSREG_CTL_AN_ENABLE];
                powerDown_q <= powerDown_q |
                    cfgVector[`PCSREG_CTL_POWER_DOWN];
                isolate_q <= cfgVector[`PCSREG_CTL_ISOLATE];
                unidir_q <= cfgVector[`PCSREG_CTL_UNIDIR];
                anRestart <= cfgVector[`PCSREG_CTL_AN_RESTART];
            end
            if (syncS_q[1])
            begin
                lossCnt_q <= 18'h00000;
                syncHeld_q <= 1'b1;
            end
            else if (lossCnt_q >= LINK_TIMER_CYC[17:0] - 18'h00001)
                syncHeld_q <= 1'b0;
            else
                lossCnt_q <= lossCnt_q + 18'h00001;
            // hardware set wins over the clear-on-read
            if (rfS_q[1])
                remoteFault_q <= 1'b1;
            else if (statusRead)
                remoteFault_q <= 1'b0;
            // loss wins over the reload on read
            if (!linkNow)
                linkLatch_q <= 1'b0;
            else if (statusRead)
                linkLatch_q <= 1'b1;
            loopbackInternal <= loopback_q && !TBI_VARIANT[0];
            loopbackRequest <= loopback_q && TBI_VARIANT[0];
            powerDown <= powerDown_q && !TBI_VARIANT[0];
            isolate <= isolate_q;
            anEnable <= anEnable_q;
            unidirTx <= unidir_q && !anEnable_q;
        end
    end

endmodule // pcsreg_top
`default_nettype wire

// ==== test/pcsreg_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcsreg_top_sva
#(
    parameter [1:0] TBI_VARIANT = 2'h0,
    parameter LINK_TIMER_CYC = 250000
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mdioOut,
    input wire logic mdioOe,
    input wire logic coreReset,
    input wire logic loopbackInternal,
    input wire logic loopbackRequest,
    input wire logic powerDown,
    input wire logic isolate,
    input wire logic anEnable,
    input wire logic anRestart,
    input wire logic unidirTx
);
    logic [7:0] oeLen_q;
    // length of one read drive, 17 mdc periods of 8 clk each
    always_ff @(posedge clk)
        oeLen_q <= (rst_n && mdioOe) ? oeLen_q + 8'h01 : 8'h00;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    chk_unidir_gate:
        assert property (unidirTx |-> !anEnable)
        else $error("unidirectional transmit with negotiation on");
    chk_restart_pulse:
        assert property (anRestart |=> !anRestart)
        else $error("restart pulse longer than one cycle");
    chk_lb_route:
        assert property (TBI_VARIANT[0] ? !loopbackInternal : !loopbackRequest)
        else $error("loopback on the wrong output");
    chk_pd_sticky:
        assert property ($fell(powerDown) |-> coreReset || $past(coreReset))
        else $error("power down cleared without reset");
    chk_ta_zero:
        assert property ($rose(mdioOe) |-> !mdioOut)
        else $error("turnaround bit not zero");
    chk_read_len:
        assert property ($fell(mdioOe) |-> oeLen_q >= 8'h82 && oeLen_q <= 8'h8e)
        else $error("read drive of wrong length");
    chk_rst_defaults:
        assert property ($fell(coreReset) |-> isolate && anEnable
            && !powerDown && !loopbackInternal && !unidirTx)
        else $error("outputs not at defaults after reset");
    chk_rst_selfclr:
        assert property ($rose(coreReset) |-> ##[1:8] !coreReset)
        else $error("core reset does not clear itself");
endmodule // pcsreg_top_sva
bind pcsreg_top pcsreg_top_sva #(.TBI_VARIANT(TBI_VARIANT),
    .LINK_TIMER_CYC(LINK_TIMER_CYC)) pcsreg_top_sva_i (.clk(clk),
    .rst_n(rst_n), .mdioOut(mdioOut), .mdioOe(mdioOe),
    .coreReset(coreReset), .loopbackInternal(loopbackInternal),
    .loopbackRequest(loopbackRequest), .powerDown(powerDown),
    .isolate(isolate), .anEnable(anEnable), .anRestart(anRestart),
    .unidirTx(unidirTx));
`default_nettype wire

// ==== test/pcsreg_mdio_master.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pcsreg_defs.vh"
module pcsreg_mdio_master
(
    output logic mdc,
    output wire logic mdio,
    input wire logic mdioOut,
    input wire logic mdioOe,
    output logic [15:0] rdWord,
    output logic rdToggle
);
    logic drv;
    logic drvOe;
    // released line floats to the pull-up level
    assign mdio = mdioOe ? mdioOut : (drvOe ? drv : 1'b1);
    initial
    begin
        mdc = 1'b0;
        drvOe = 1'b0;
        drv = 1'b1;
        rdWord = 16'h0000;
        rdToggle = 1'b0;
    end
    // mdc stands low between frames; read bits taken late in the period
    // since the device answers a few clk after each falling mdc
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
        input logic [4:0] ra, input logic [15:0] wd);
        logic [63:0] bits;
        bits = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
        #7;
        for (int i = 63; i >= 0; i--)
        begin
            drvOe = !(op == `PCSREG_OP_READ && i < 18);
            drv = bits[i];
            #160 mdc = 1'b1;
            #159;
            if (i < 16)
                rdWord[i] = mdio;
            #1 mdc = 1'b0;
        end
        drvOe = 1'b0;
        if (op == `PCSREG_OP_READ)
            rdToggle = !rdToggle;
    endtask
endmodule // pcsreg_mdio_master
`default_nettype wire

// ==== test/pcsreg_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pcsreg_defs.vh"
module pcsreg_top_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    logic clockLocked = 1'b1;
    logic cfgValid = 1'b0;
    logic [15:0] cfgVector = 16'h0000;
    logic syncStatus = 1'b0;
    logic anComplete = 1'b0;
    logic xcvrResetDone = 1'b0;
    logic remoteFault = 1'b0;
    wire logic mdc, mdio, mdioOut, mdioOe, coreReset, lbInt, lbReq;
    wire logic pd, iso, anEn, anRst, uni, rdToggle;
    wire logic [15:0] rdWord;
    wire logic lbIntTbi, lbReqTbi, pdTbi;
    logic [15:0] restarts = 16'h0000;
    logic [15:0] resets = 16'h0000;
    logic crPrev = 1'b1;
    logic [31:0] expQ[$];
    logic [31:0] note;
    logic [15:0] w;
    integer seed = 52;
    int failures = 0;
    int cmp_count = 0;
    initial
        forever #20 clk = ~clk;
    pcsreg_top #(.TBI_VARIANT(2'h0), .LINK_TIMER_CYC(20)) pcsreg_top_i (
        .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .clockLocked(clockLocked),
        .phyAddr(5'h05), .mdc(mdc), .mdioIn(mdio), .mdioOut(mdioOut),
        .mdioOe(mdioOe), .cfgValid(cfgValid), .cfgVector(cfgVector),
        .syncStatus(syncStatus), .anComplete(anComplete),
        .xcvrResetDone(xcvrResetDone), .remoteFault(remoteFault),
        .coreReset(coreReset), .loopbackInternal(lbInt),
        .loopbackRequest(lbReq), .powerDown(pd), .isolate(iso),
        .anEnable(anEn), .anRestart(anRst), .unidirTx(uni));
    // ten-bit variant listens to the same frames; its drive stays off the bus
    pcsreg_top #(.TBI_VARIANT(2'h1), .LINK_TIMER_CYC(20)) pcsreg_top_tbi_i (
        .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .clockLocked(clockLocked),
        .phyAddr(5'h05), .mdc(mdc), .mdioIn(mdio), .mdioOut(),
        .mdioOe(), .cfgValid(cfgValid), .cfgVector(cfgVector),
        .syncStatus(syncStatus), .anComplete(anComplete),
        .xcvrResetDone(xcvrResetDone), .remoteFault(remoteFault),
        .coreReset(), .loopbackInternal(lbIntTbi),
        .loopbackRequest(lbReqTbi), .powerDown(pdTbi), .isolate(),
        .anEnable(), .anRestart(), .unidirTx());
    // pulses counted at the falling edge, well after they settle
    always @(negedge clk)
    begin
        crPrev <= coreReset;
        if (anRst)
            restarts <= restarts + 16'h0001;
        if (coreReset && !crPrev)
            resets <= resets + 16'h0001;
    end
    pcsreg_mdio_master pcsreg_mdio_master_i (.mdc(mdc), .mdio(mdio),
        .mdioOut(mdioOut), .mdioOe(mdioOe), .rdWord(rdWord),
        .rdToggle(rdToggle));
    task check_word(input logic [15:0] e, input logic [15:0] m,
        input logic [15:0] g);
        cmp_count++;
        if ((g & m) !== (e & m))
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g & m, e);
        end
    endtask
    task check_pin(input logic e, input logic g);
        check_word({15'h0000, e}, 16'h0001, {15'h0000, g});
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task wr(input logic [4:0] ra, input logic [15:0] d);
        pcsreg_mdio_master_i.xfer(`PCSREG_OP_WRITE, 5'h05, ra, d);
        repeat (8) @(negedge clk);
    endtask
    task rd(input logic [4:0] phy, input logic [4:0] ra,
        input logic [15:0] e, input logic [15:0] m);
        expQ.push_back({m, e});
        pcsreg_mdio_master_i.xfer(`PCSREG_OP_READ, phy, ra, 16'h0000);
        @(negedge clk);
    endtask
    // oldest note pairs with each finished read
    always @(rdToggle)
    begin
        if (expQ.size() > 0)
        begin
            note = expQ.pop_front();
            check_word(note[15:0], note[31:16], rdWord);
        end
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        failures++;
        give_verdict();
    end
    initial
    begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check_pin(1'b1, iso);
        check_pin(1'b1, anEn);
        rd(5'h05, 5'h00, 16'h1540, 16'hffff);
        wr(5'h00, 16'h7e3f);
        check_pin(1'b1, lbInt);
        check_pin(1'b1, pd);
        check_pin(1'b0, lbReq);
        check_pin(1'b1, lbReqTbi);
        check_pin(1'b0, lbIntTbi);
        check_pin(1'b0, pdTbi);
        check_word(16'h0001, 16'hffff, restarts);
        rd(5'h05, 5'h00, 16'h5d60, 16'hffff);
        wr(5'h00, 16'h0020);
        check_pin(1'b1, uni);
        rd(5'h05, 5'h00, 16'h0960, 16'hffff);
        repeat (4)
        begin
            w = $random(seed);
            w[15] = 1'b0;
            wr(5'h00, w);
            check_pin(w[5] & ~w[12], uni);
            rd(5'h05, 5'h00, (w & 16'h5420) | 16'h0940, 16'hffff);
        end
        wr(5'h03, 16'hffff);
        rd(5'h05, 5'h03, 16'h0000, 16'hffff);
        rd(5'h09, 5'h00, 16'hffff, 16'hffff);
        wr(5'h00, 16'h8000);
        check_pin(1'b0, pd);
        check_word(16'h0001, 16'hffff, resets);
        check_pin(1'b0, coreReset);
        rd(5'h05, 5'h00, 16'h1540, 16'hffff);
        cfgVector = 16'h4020;
        cfgValid = 1'b1;
        @(negedge clk);
        cfgValid = 1'b0;
        repeat (4) @(negedge clk);
        check_pin(1'b0, iso);
        rd(5'h05, 5'h00, 16'h4160, 16'hffff);
        // clock lock loss must act like a reset
        clockLocked = 1'b0;
        repeat (4) @(negedge clk);
        clockLocked = 1'b1;
        repeat (4) @(negedge clk);
        check_pin(1'b1, iso);
        check_pin(1'b0, lbInt);
        wr(5'h00, 16'h1000);
        wr(5'h01, 16'hffff);
        syncStatus = 1'b1;
        anComplete = 1'b1;
        xcvrResetDone = 1'b1;
        repeat (10) @(negedge clk);
        rd(5'h05, 5'h01, 16'h01e8, 16'hfffb);
        rd(5'h05, 5'h01, 16'h01ec, 16'hffff);
        remoteFault = 1'b1;
        repeat (4) @(negedge clk);
        remoteFault = 1'b0;
        rd(5'h05, 5'h01, 16'h01fc, 16'hffff);
        rd(5'h05, 5'h01, 16'h01ec, 16'hffff);
        // drop shorter than the link timer must not reach the status
        syncStatus = 1'b0;
        repeat (5) @(negedge clk);
        syncStatus = 1'b1;
        rd(5'h05, 5'h01, 16'h01ec, 16'hffff);
        syncStatus = 1'b0;
        repeat (60) @(negedge clk);
        syncStatus = 1'b1;
        rd(5'h05, 5'h01, 16'h01e8, 16'hffff);
        rd(5'h05, 5'h01, 16'h01ec, 16'hffff);
        anComplete = 1'b0;
        rd(5'h05, 5'h01, 16'h01c8, 16'hfffb);
        rd(5'h05, 5'h01, 16'h01c8, 16'hffff);
        give_verdict();
    end
endmodule // pcsreg_top_tb_top
`default_nettype wire
